// *** hw/flash_pkg.sv ***
package flash_pkg;
  // Core clock and operation timing
  localparam int CLK_MHZ       = 50;
  localparam int ERASE_TIME_NS = 1000;
  localparam int PROG_TIME_NS  = 1000;
  localparam int ERASE_CYC     = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_CYC      = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PAGE_BYTES    = 128;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_AUX1 = 8'h04;
  localparam logic [7:0] OFF_AUX  = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;

  // Field positions and reset values
  localparam int KEY_HI       = 7;
  localparam int KEY_LO       = 4;
  localparam int LMS_BIT      = 3;
  localparam int SPACE_HI     = 2;
  localparam int SPACE_LO     = 1;
  localparam int BUSY_BIT     = 0;
  localparam int BOOT_MAP_BIT = 0;
  localparam int EXT_RAM_BIT  = 1;
  localparam int ABORT_BIT    = 8;
  localparam int ARMED_BIT    = 9;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic       AUX_RST  = 1'b0;

  // Launch key nibbles
  localparam logic [3:0] KEY_ARM = 4'h5;
  localparam logic [3:0] KEY_GO  = 4'hA;

  // Address map of the core spaces
  localparam logic [15:0] EXTRA_ROW_FIRST = 16'hFF80;
  localparam logic [15:0] BOOT_FIRST = 16'hF800;
  localparam logic [15:0] SEC_ADDR   = 16'h0000;

  typedef enum logic [1:0] {
    SP_USER = 2'b00,
    SP_EXTRA_ROW = 2'b01,
    SP_SEC  = 2'b10,
    SP_RSVD = 2'b11
  } space_t;

  typedef enum logic [2:0] {
    SRC_EXT  = 3'b000,
    SRC_USER = 3'b001,
    SRC_EXTRA_ROW = 3'b010,
    SRC_SEC  = 3'b011,
    SRC_BOOT = 3'b100
  } code_src_t;

  typedef enum logic {
    KEY_LOCKED = 1'b0,
    KEY_ARMED  = 1'b1
  } key_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ERASE = 2'b01,
    SEQ_PROG  = 2'b10,
    SEQ_DONE  = 2'b11
  } seq_state_t;

  // Data-space write from the core
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } dwr_t;

  // One byte operation toward the flash array
  typedef struct packed {
    logic       erase;
    logic       prog;
    space_t     target;
    logic [7:0] page;
    logic [6:0] col;
    logic [7:0] data;
  } nvm_cmd_t;

  // Address lies in the user array window
  function automatic logic in_user(input logic [15:0] a);
    return a[15] == 1'b0;
  endfunction

  // Address lies in the extra row window
  function automatic logic in_extra_row(input logic [15:0] a);
    return a >= EXTRA_ROW_FIRST;
  endfunction
endpackage

// *** hw/col_latch.sv ***
`timescale 1ns/1ps
module col_latch #(
  parameter int BYTES = 128
) (
  // Clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     reset_in,
  // Load and clear
  input  wire logic                     wr_in,
  input  wire logic [$clog2(BYTES)-1:0] idx_in,
  input  wire logic [7:0]               data_in,
  input  wire logic                     clr_in,
  // Read side
  input  wire logic [$clog2(BYTES)-1:0] rd_idx_in,
  output logic      [7:0]               rd_data_out,
  output logic      [BYTES-1:0]         mask_out
);
  logic [7:0] mem_reg [BYTES];

  if (BYTES != 128) begin : g_chk
    $error("col_latch serves a 128 byte page only");
  end

  // Byte storage, loaded one column at a time
  always_ff @(posedge sys_clk_in) begin
    if (wr_in) begin
      mem_reg[idx_in] <= data_in;
    end
  end

  // Loaded-byte mask; a load wins over a clear
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mask_out <= '0;
    end else begin
      if (clr_in) begin
        mask_out <= '0;
      end
      if (wr_in) begin
        mask_out[idx_in] <= 1'b1;
      end
    end
  end

  assign rd_data_out = mem_reg[rd_idx_in];
endmodule

// *** hw/prog_seq.sv ***
`timescale 1ns/1ps
module prog_seq #(
  parameter int BYTES     = 128,
  parameter int ERASE_CYC = flash_pkg::ERASE_CYC,
  parameter int PROG_CYC  = flash_pkg::PROG_CYC
) (
  // Clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     reset_in,
  // Launch
  input  wire logic                     start_in,
  input  wire flash_pkg::space_t        target_in,
  input  wire logic [7:0]               page_in,
  // Column latches
  input  wire logic [BYTES-1:0]         mask_in,
  input  wire logic [7:0]               data_in,
  output logic      [$clog2(BYTES)-1:0] idx_out,
  // Status and array command
  output logic                          busy_out,
  output logic                          done_out,
  output flash_pkg::nvm_cmd_t           cmd_out
);
  localparam int CW = 16;
  localparam int IW = $clog2(BYTES);
  localparam logic [IW-1:0] LAST = IW'(BYTES - 1);

  flash_pkg::seq_state_t state_reg;
  logic [CW-1:0]         cnt_reg;
  flash_pkg::space_t     target_reg;
  logic [7:0]            page_reg;
  logic                  hit;
  logic                  erasing;

  if (ERASE_CYC < 1 || PROG_CYC < 1 || ERASE_CYC >= 2**CW ||
      PROG_CYC >= 2**CW) begin : g_chk
    $error("prog_seq timing counts out of range");
  end

  // Only loaded bytes are touched
  assign hit     = mask_in[idx_out];
  assign erasing = state_reg == flash_pkg::SEQ_ERASE;

  // Erase pass over the loaded bytes, then a program pass
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg  <= flash_pkg::SEQ_IDLE;
      cnt_reg    <= '0;
      idx_out    <= '0;
      target_reg <= flash_pkg::SP_USER;
      page_reg   <= '0;
      cmd_out    <= '0;
      done_out   <= 1'b0;
    end else begin
      cmd_out.erase <= 1'b0;
      cmd_out.prog  <= 1'b0;
      done_out      <= 1'b0;
      if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      case (state_reg)
        flash_pkg::SEQ_IDLE: begin
          if (start_in) begin
            state_reg  <= flash_pkg::SEQ_ERASE;
            idx_out    <= '0;
            target_reg <= target_in;
            page_reg   <= page_in;
          end
        end
        flash_pkg::SEQ_ERASE, flash_pkg::SEQ_PROG: begin
          if (cnt_reg == '0) begin
            cmd_out.erase  <= hit && erasing;
            cmd_out.prog   <= hit && !erasing;
            cmd_out.target <= target_reg;
            cmd_out.page   <= page_reg;
            cmd_out.col    <= 7'(idx_out);
            cmd_out.data   <= data_in;
            if (hit) begin
              cnt_reg <= erasing ? CW'(ERASE_CYC) : CW'(PROG_CYC);
            end
            idx_out <= idx_out + 1'b1;
            if (idx_out == LAST) begin
              state_reg <= erasing ? flash_pkg::SEQ_PROG
                                   : flash_pkg::SEQ_DONE;
            end
          end
        end
        flash_pkg::SEQ_DONE: begin
          if (cnt_reg == '0) begin
            state_reg <= flash_pkg::SEQ_IDLE;
            done_out  <= 1'b1;
          end
        end
        default: state_reg <= flash_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Busy while any pass is running
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= start_in || (state_reg != flash_pkg::SEQ_IDLE &&
                  !(state_reg == flash_pkg::SEQ_DONE &&
                    cnt_reg == '0));
    end
  end
endmodule

// *** hw/flash_program_control.sv ***
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Without mapping, user flash is read-only through code-space reads.
// - With latch map set, data writes 0000h-7FFFh go to column latches.
// - Address bits 6-0 pick the byte, bits 14-7 pick the page.
// - Latch map set overrides the external RAM select on data writes.
// - Space select 00 user, 01 extra row, 10 security byte, 11 reserved.
// - Programming starts only after key 5 then key A writes.
// - Key A programs user, extra row or security byte; 11 or lone 5 do nothing.
// - Any instruction between the two key writes aborts the launch.
// - Busy is set during erase and program, cleared when done.
// - Boot flash map bit shows boot flash at F800h-FFFFh; with space 01 the extra row takes FF80h-FFFFh.
// - Latches accept one to 128 bytes before a launch.
// - Launch erases only loaded bytes, then programs them.
// - Page of the latest latch write to 0000h-7FFFh is the page programmed.
// - Launch key is honoured only when run from boot flash.
// - Control: key bits 7-4, latch map 3, space 2-1, busy 0.
// - Busy bit is hardware only; software writes do not change it.
module flash_program_control #(
  parameter int PAGE_BYTES = flash_pkg::PAGE_BYTES
) (
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_in,
  // APB slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [7:0]           paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  // Core accesses
  input  wire logic                 dwr_valid_in,
  input  wire flash_pkg::dwr_t      dwr_in,
  input  wire logic                 code_rd_in,
  input  wire logic [15:0]          code_addr_in,
  input  wire logic                 instr_step_in,
  input  wire logic                 exec_boot_in,
  // Data-space write toward RAM
  output logic                      xram_wr_out,
  output logic                      xram_ext_out,
  output flash_pkg::dwr_t           xram_req_out,
  // Code-space view
  output logic                      code_valid_out,
  output flash_pkg::code_src_t      code_src_out,
  output logic      [15:0]          code_addr_out,
  // Flash array and status
  output flash_pkg::nvm_cmd_t       nvm_cmd_out,
  output logic                      busy_out,
  output logic                      boot_flash_map_out,
  output logic                      ext_ram_select_out
);
  localparam int IW = $clog2(PAGE_BYTES);

  logic [7:1]            ctrl_reg;
  logic                  aux_boot_reg;
  logic                  aux_ext_reg;
  logic [7:0]            page_reg;
  logic                  abort_reg;
  flash_pkg::key_state_t key_reg;
  flash_pkg::key_state_t key_next;

  if (PAGE_BYTES != 128) begin : g_chk
    $error("flash_program_control serves a 128 byte page only");
  end

  // APB decode
  wire        apb_acc  = psel_in && penable_in && pready_out;
  wire        apb_wr   = apb_acc && pwrite_in;
  wire        hit_ctrl = paddr_in == flash_pkg::OFF_CTRL;
  wire        hit_aux1 = paddr_in == flash_pkg::OFF_AUX1;
  wire        hit_aux  = paddr_in == flash_pkg::OFF_AUX;
  wire        hit_stat = paddr_in == flash_pkg::OFF_STAT;
  wire        mapped   = hit_ctrl || hit_aux1 || hit_aux || hit_stat;
  wire        ctrl_wr  = apb_wr && hit_ctrl;
  wire [3:0]  wr_key   = pwdata_in[flash_pkg::KEY_HI:flash_pkg::KEY_LO];
  wire        wr_lms   = pwdata_in[flash_pkg::LMS_BIT];
  wire [1:0]  wr_space = pwdata_in[flash_pkg::SPACE_HI:flash_pkg::SPACE_LO];
  wire        lms      = ctrl_reg[flash_pkg::LMS_BIT];
  wire [1:0]  space    = ctrl_reg[flash_pkg::SPACE_HI:flash_pkg::SPACE_LO];
  wire        busy;
  wire        done;

  // Launch key decode
  wire key_arm = ctrl_wr && wr_key == flash_pkg::KEY_ARM;
  wire key_go  = ctrl_wr && wr_key == flash_pkg::KEY_GO;
  wire armed   = key_reg == flash_pkg::KEY_ARMED;
  wire launch  = key_go && armed && exec_boot_in && !busy &&
                 wr_space != flash_pkg::SP_RSVD;
  wire abort   = armed && ((ctrl_wr && !key_go) ||
                 (instr_step_in && !ctrl_wr));

  // Read data mux
  wire [31:0] rd_word =
    hit_ctrl ? {24'h000000, ctrl_reg, busy_out} :
    hit_aux1 ? {31'h00000000, aux_boot_reg} :
    hit_aux  ? {30'h00000000, aux_ext_reg, 1'b0} :
    hit_stat ? {22'h000000, armed, abort_reg, page_reg} : 32'h00000000;

  // Data-space write steering
  wire [15:0] dwa      = dwr_in.addr;
  wire        lat_win  = flash_pkg::in_user(dwa) ||
                         flash_pkg::in_extra_row(dwa);
  wire        to_latch = dwr_valid_in && lms && lat_win;
  wire        lat_wr   = to_latch && !busy;
  wire        to_xram  = dwr_valid_in && !(lms && lat_win);

  // Code-space view selection
  wire [15:0] ca       = code_addr_in;
  wire        boot_hit = aux_boot_reg && ca >= flash_pkg::BOOT_FIRST;
  wire flash_pkg::code_src_t src =
    (space == flash_pkg::SP_EXTRA_ROW && flash_pkg::in_extra_row(ca)) ?
      flash_pkg::SRC_EXTRA_ROW :
    boot_hit ? flash_pkg::SRC_BOOT :
    (space == flash_pkg::SP_SEC && ca == flash_pkg::SEC_ADDR) ?
      flash_pkg::SRC_SEC :
    flash_pkg::in_user(ca) ? flash_pkg::SRC_USER :
    flash_pkg::SRC_EXT;

  wire [IW-1:0]   seq_idx;
  wire [7:0]      lat_data;
  wire [PAGE_BYTES-1:0] lat_mask;

  // Column latch storage
  col_latch #(
    .BYTES       (PAGE_BYTES)
  ) u_latch (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .wr_in       (lat_wr),
    .idx_in      (dwa[IW-1:0]),
    .data_in     (dwr_in.data),
    .clr_in      (done),
    .rd_idx_in   (seq_idx),
    .rd_data_out (lat_data),
    .mask_out    (lat_mask)
  );

  // Erase and program sequencer
  prog_seq #(
    .BYTES      (PAGE_BYTES)
  ) u_seq (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .start_in   (launch),
    .target_in  (flash_pkg::space_t'(wr_space)),
    .page_in    (page_reg),
    .mask_in    (lat_mask),
    .data_in    (lat_data),
    .idx_out    (seq_idx),
    .busy_out   (busy),
    .done_out   (done),
    .cmd_out    (nvm_cmd_out)
  );

  assign busy_out = busy;

  // Key state machine
  always_comb begin
    key_next = key_reg;
    case (key_reg)
      flash_pkg::KEY_LOCKED: begin
        if (key_arm && exec_boot_in) begin
          key_next = flash_pkg::KEY_ARMED;
        end
      end
      flash_pkg::KEY_ARMED: begin
        if (key_go || abort) begin
          key_next = flash_pkg::KEY_LOCKED;
        end
      end
      default: key_next = flash_pkg::KEY_LOCKED;
    endcase
  end

  // APB handshake, one wait state per access
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && penable_in && !pready_out;
      prdata_out  <= rd_word;
      pslverr_out <= psel_in && penable_in && !pready_out && !mapped;
    end
  end

  // Software registers; busy bit is never stored
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_reg     <= flash_pkg::CTRL_RST[7:1];
      aux_boot_reg <= flash_pkg::AUX_RST;
      aux_ext_reg  <= flash_pkg::AUX_RST;
      key_reg      <= flash_pkg::KEY_LOCKED;
    end else begin
      key_reg <= key_next;
      if (ctrl_wr) begin
        ctrl_reg <= pwdata_in[7:1];
      end
      if (apb_wr && hit_aux1) begin
        aux_boot_reg <= pwdata_in[flash_pkg::BOOT_MAP_BIT];
      end
      if (apb_wr && hit_aux) begin
        aux_ext_reg <= pwdata_in[flash_pkg::EXT_RAM_BIT];
      end
    end
  end

  // Target page and abort status
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      page_reg  <= '0;
      abort_reg <= 1'b0;
    end else begin
      if (lat_wr && flash_pkg::in_user(dwa)) begin
        page_reg <= dwa[14:7];
      end
      if (abort) begin
        abort_reg <= 1'b1;
      end else if (launch) begin
        abort_reg <= 1'b0;
      end
    end
  end

  // Registered core-side outputs
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      xram_wr_out        <= 1'b0;
      xram_ext_out       <= 1'b0;
      xram_req_out       <= '0;
      code_valid_out     <= 1'b0;
      code_src_out       <= flash_pkg::SRC_EXT;
      code_addr_out      <= '0;
      boot_flash_map_out <= 1'b0;
      ext_ram_select_out <= 1'b0;
    end else begin
      xram_wr_out        <= to_xram;
      xram_ext_out       <= aux_ext_reg;
      xram_req_out       <= dwr_in;
      code_valid_out     <= code_rd_in;
      code_src_out       <= src;
      code_addr_out      <= ca;
      boot_flash_map_out <= aux_boot_reg;
      ext_ram_select_out <= aux_ext_reg;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  property p_busy_launch;
    launch |=> busy_out [*2];
  endproperty
  a_busy_launch: assert property (p_busy_launch)
    else $error("busy did not follow launch");

  property p_busy_cause;
    $rose(busy_out) |-> $past(launch);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without a launch");

  property p_go_needs_arm;
    key_go && !armed |=> !busy_out || $past(busy_out);
  endproperty
  a_go_needs_arm: assert property (p_go_needs_arm)
    else $error("launch without arm key");

  property p_rsvd;
    key_go && wr_space == flash_pkg::SP_RSVD |=> $stable(busy_out);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved space started programming");

  property p_abort;
    armed && instr_step_in && !ctrl_wr |=> !armed ##1 !busy_out;
  endproperty
  a_abort: assert property (p_abort)
    else $error("instruction between keys did not abort");

  property p_boot_only;
    key_go && !exec_boot_in |=> !$rose(busy_out);
  endproperty
  a_boot_only: assert property (p_boot_only)
    else $error("launch honoured outside boot flash");

  property p_relock;
    key_go |=> key_reg == flash_pkg::KEY_LOCKED;
  endproperty
  a_relock: assert property (p_relock)
    else $error("key machine stayed armed");

  property p_latch_steer;
    dwr_valid_in && lms && flash_pkg::in_user(dwa) |=> !xram_wr_out;
  endproperty
  a_latch_steer: assert property (p_latch_steer)
    else $error("latch write leaked to RAM");

  property p_page;
    lat_wr && flash_pkg::in_user(dwa) |=> page_reg == $past(dwa[14:7]);
  endproperty
  a_page: assert property (p_page)
    else $error("page address not taken from latch write");

  property p_boot_map;
    code_rd_in && boot_hit && space != flash_pkg::SP_EXTRA_ROW
      |=> code_src_out == flash_pkg::SRC_BOOT;
  endproperty
  a_boot_map: assert property (p_boot_map)
    else $error("boot flash not mapped");

  property p_user_view;
    code_rd_in && space == flash_pkg::SP_USER && !ca[15]
      |=> code_src_out == flash_pkg::SRC_USER;
  endproperty
  a_user_view: assert property (p_user_view)
    else $error("user array not visible in code space");
endmodule

// *** testbench/core_model.sv ***
`timescale 1ns/1ps
// Core side: data writes, code reads, steps and boot fetch
module core_model (
  // Clock
  input  wire logic                 sys_clk_in,
  // Toward the block
  output logic                      dwr_valid_out,
  output flash_pkg::dwr_t           dwr_out,
  output logic                      code_rd_out,
  output logic      [15:0]          code_addr_out,
  output logic                      step_out,
  output logic                      boot_out,
  // Answers
  input  wire logic                 xram_wr_in,
  input  wire flash_pkg::code_src_t src_in
);
  // Idle levels; interrupts stay off so no stray step
  initial begin
    dwr_valid_out = 1'b0;
    dwr_out = '0;
    code_rd_out = 1'b0;
    code_addr_out = 16'h0000;
    step_out = 1'b0;
    boot_out = 1'b1;
  end
  // One data write; the released bus shows the inverse
  task automatic dwrite(input logic [15:0] a, input logic [7:0] d,
                        output logic wr);
    @(posedge sys_clk_in);
    dwr_valid_out <= 1'b1;
    dwr_out <= '{addr: a, data: d};
    @(posedge sys_clk_in);
    dwr_valid_out <= 1'b0;
    dwr_out <= ~dwr_out;
    #1 wr = xram_wr_in;
  endtask
  // One code-space read
  task automatic cread(input logic [15:0] a,
                       output flash_pkg::code_src_t s);
    @(posedge sys_clk_in);
    code_rd_out <= 1'b1;
    code_addr_out <= a;
    @(posedge sys_clk_in);
    code_rd_out <= 1'b0;
    code_addr_out <= ~a;
    #1 s = src_in;
  endtask
  // One retired instruction
  task automatic step();
    @(posedge sys_clk_in);
    step_out <= 1'b1;
    @(posedge sys_clk_in);
    step_out <= 1'b0;
  endtask
  // Fetch region of the running code
  task automatic set_boot(input logic b);
    @(posedge sys_clk_in);
    boot_out <= b;
  endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
// Bench for the flash program control block
module tb_top;
  logic                 sys_clk, rst, psel, pen, pwr, pready, pslverr;
  logic                 er, w, xw, xext, cv, busy, bmap, eram;
  logic                 dv, crd, step, boot;
  logic [7:0]           paddr, pg;
  logic [31:0]          pwdata, prdata, rd;
  logic [15:0]          caddr, caddr_o, a;
  flash_pkg::dwr_t      dwr, xreq;
  flash_pkg::code_src_t src, s;
  flash_pkg::nvm_cmd_t  cmd, pc;
  int                   err_count, compares, seed, n_er, n_pr;

  flash_program_control DUT (.sys_clk_in(sys_clk), .reset_in(rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .dwr_valid_in(dv),
    .dwr_in(dwr), .code_rd_in(crd), .code_addr_in(caddr),
    .instr_step_in(step), .exec_boot_in(boot), .xram_wr_out(xw),
    .xram_ext_out(xext), .xram_req_out(xreq), .code_valid_out(cv),
    .code_src_out(src), .code_addr_out(caddr_o), .nvm_cmd_out(cmd),
    .busy_out(busy), .boot_flash_map_out(bmap),
    .ext_ram_select_out(eram));
  core_model core (.sys_clk_in(sys_clk), .dwr_valid_out(dv),
    .dwr_out(dwr), .code_rd_out(crd), .code_addr_out(caddr),
    .step_out(step), .boot_out(boot), .xram_wr_in(xw), .src_in(src));

  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end
  // Count array pulses and note the page
  always @(posedge sys_clk) begin
    if (cmd.erase === 1'b1) begin
      n_er++;
      pg <= cmd.page;
    end
    if (cmd.prog === 1'b1) begin
      n_pr++;
      pc <= cmd;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // APB transfer: setup, access until pready
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    pen <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  function automatic flash_pkg::code_src_t exp_src(
      input logic [1:0] sp, input logic bm, input logic [15:0] ad);
    if (sp == 2'b01 && ad >= 16'hFF80) return flash_pkg::SRC_EXTRA_ROW;
    if (bm && ad >= 16'hF800) return flash_pkg::SRC_BOOT;
    if (sp == 2'b10 && ad == 16'h0000) return flash_pkg::SRC_SEC;
    if (!ad[15]) return flash_pkg::SRC_USER;
    return flash_pkg::SRC_EXT;
  endfunction
  // Load n latches, send the key pair, follow the operation
  task automatic run(input logic [1:0] sp, input int n,
                     input logic brk, input logic bt);
    logic       go;
    logic [7:0] pr;
    logic [7:0] dl;
    go = sp != 2'b11 && !brk && bt;
    pr = $random(seed);
    n_er = 0;
    n_pr = 0;
    apb(1'b1, 8'h00, {28'h0, 1'b1, sp, 1'b0});
    for (int k = 0; k < n; k++) begin
      a = sp == 2'b01 ? 16'hFF80 : 16'h0000;
      if (sp == 2'b00) a = {1'b0, k == n - 1 ? pr : ~pr, 7'h00};
      dl = 8'($random(seed));
      core.dwrite(a + 16'(k), dl, w);
      chk(32'(w), 32'h0);
    end
    core.set_boot(bt);
    apb(1'b1, 8'h00, {24'h0, 4'h5, 1'b0, sp, 1'b0});
    if (brk) core.step();
    apb(1'b1, 8'h00, {24'h0, 4'hA, 1'b0, sp, 1'b0});
    repeat (3) @(posedge sys_clk);
    #1 chk(32'(busy), 32'(go));
    apb(1'b0, 8'h00, 32'h0);
    chk(32'(rd[0]), 32'(go));
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge sys_clk);
    chk(32'(busy), 32'h0);
    chk(32'(n_er), go ? n : 0);
    chk(32'(n_pr), go ? n : 0);
    if (go) chk({pc.target, pc.col, pc.data}, {sp, 7'(n - 1), dl});
    if (go && sp == 2'b00) chk(32'(pg), 32'(pr));
    apb(1'b0, 8'h0C, 32'h0);
    if (brk || go) chk(32'(rd[8]), 32'(brk));
    apb(1'b1, 8'h00, 32'h0);
    core.set_boot(1'b1);
    $display("run space %0d bytes %0d done", sp, n);
  endtask

  initial begin
    seed = 83;
    err_count = 0;
    compares = 0;
    {rst, psel, pen, pwr, paddr, pwdata} = {1'b1, 43'h0};
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h01);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(er), 32'h1);
    $display("registers done");
    // Code-space views for spaces 00, 01 and 10, with boot map off and on
    for (int i = 0; i < 6; i++) begin
      a = $random(seed);
      if (i[0]) a[15:7] = 9'h1FF;
      if (i == 2) a = 16'h0000;
      apb(1'b1, 8'h04, 32'(i > 2));
      apb(1'b1, 8'h00, 32'((i % 3) * 2));
      core.cread(a, s);
      chk(32'(s), 32'(exp_src(2'(i % 3), i > 2, a)));
      chk({cv, caddr_o}, {1'b1, a});
      chk(32'(bmap), 32'(i > 2));
    end
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    $display("views done");
    // Ext RAM select steers plain writes to RAM
    apb(1'b1, 8'h08, 32'h2);
    core.dwrite(16'h1234, 8'h5A, w);
    chk({eram, xext, w}, 32'h7);
    chk(32'(xreq), {8'h00, 16'h1234, 8'h5A});
    $display("steering done");
    for (int sp = 0; sp < 4; sp++) run(2'(sp), 1, 1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'hA0);
    repeat (3) @(posedge sys_clk);
    #1 chk(32'(busy), 32'h0);
    $display("relock done");
    run(2'b00, 128, 1'b0, 1'b1);
    run(2'b00, 3, 1'b1, 1'b1);
    run(2'b00, 2, 1'b0, 1'b0);
    end_sim();
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
endmodule
